// ===== design/i2c_regulator_control_slave.sv
// two-wire slave interface and control registers of the step-down regulator
`timescale 1ns/1ps
`include "regctl_map.svh"
// Summary of operation
// - works at 100 and 400 kbps; high-speed mode is neither supported nor recognised
// - slave only: never makes START, STOP or clock pulses, never drives the clock
// - START is data falling while clock is high
// - STOP is data rising while clock is high
// - bus counts as busy from START until after STOP
// - bytes are eight bits, MSB first, each followed by one acknowledge bit
// - no limit on the number of bytes within one transfer
// - answers to 7-bit address 1110010; eighth bit gives read or write
// - write: START, address+0, ack, sub-address, ack, data, ack, STOP
// - read without sub-address returns the register last addressed by a write
// - bits 6:4 of control select switching frequency, reset code 000
// - bit 1 of control: 0 pulse-skip (reset), 1 forced continuous
// - bit 0 of control: 0 converter runs (reset), 1 converter off
// - bits 3:0 of voltage register give output code, reset 0000
module i2c_regulator_control_slave (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	output logic            bus_busy_o,
	output logic [2:0]      switching_freq_select_o,
	output logic            forced_continuous_mode_o,
	output logic            converter_disable_o,
	output logic [3:0]      output_voltage_code_o
);
	import regctl_pkg::*;

	// link domain: one flop captures each data bit on the rising clock edge
	// and a toggle announces it; the toggle crosses, the bit waits for it
	logic                   link_bit_q;
	logic                   link_tog_q;

	always_ff @(posedge scl_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link_bit_q <= 1'h0;
			link_tog_q <= 1'h0;
		end else begin
			link_bit_q <= sda_i;
			link_tog_q <= ~link_tog_q;
		end
	end

	// clk_i domain: bus levels and the toggle pass two flip-flops first
	logic [2:0]             sync_in;
	logic [2:0]             sync_out;
	logic                   scl_s;
	logic                   sda_s;
	logic                   tog_s;

	assign sync_in = {scl_i, sda_i, link_tog_q};

	sync2 #(
		.WIDTH(3)
	) u_sync (
		.clk_i    (clk_i),
		.reset_n_i(reset_n_i),
		.async_i  (sync_in),
		.sync_o   (sync_out)
	);

	assign scl_s = sync_out[2];
	assign sda_s = sync_out[1];
	assign tog_s = sync_out[0];

	// history of the synchronised levels for edge detection
	logic                   scl_prev_q;
	logic                   sda_prev_q;
	logic                   tog_prev_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// match the synchroniser's reset level so no false edge appears as it fills
			scl_prev_q <= 1'h0;
			sda_prev_q <= 1'h0;
			tog_prev_q <= 1'h0;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			tog_prev_q <= tog_s;
		end
	end

	// bus events; 25 ns sampling resolves 400 kbps setup and hold margins
	logic                   scl_fall;
	logic                   bit_evt;
	logic                   start_det;
	logic                   stop_det;
	logic                   rx_bit;

	assign scl_fall  = scl_prev_q & ~scl_s;
	assign bit_evt   = tog_s ^ tog_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	// stable here: the next capture is a whole bus clock period away
	assign rx_bit    = link_bit_q;

	// protocol state
	link_state_t            state_q;
	link_state_t            state_d;
	byte_phase_t            phase_q;
	byte_phase_t            phase_d;
	logic [2:0]             bit_idx_q;
	logic [2:0]             bit_idx_d;
	logic [7:0]             shift_q;
	logic [7:0]             shift_d;
	logic                   byte_full_q;
	logic                   byte_full_d;
	logic                   rw_q;
	logic                   rw_d;
	logic [7:0]             sub_q;
	logic [7:0]             sub_d;
	logic [7:0]             tx_q;
	logic [7:0]             tx_d;
	logic                   nack_q;
	logic                   nack_d;
	logic                   oe_n_q;
	logic                   oe_n_d;
	logic                   busy_q;
	logic                   busy_d;
	logic                   wr_en;

	// register file
	logic [7:0]             ctrl_q;
	logic [7:0]             volt_q;
	logic [7:0]             rdata;
	logic                   addr_match;
	logic                   sel_ctrl;
	logic                   sel_volt;

	assign addr_match = (shift_q[7:1] == `RC_SLAVE_ADDR);
	assign sel_ctrl   = (sub_q == `RC_SUB_CONVERTER_CONTROL);
	assign sel_volt   = (sub_q == `RC_SUB_OUTPUT_VOLTAGE);
	// unmapped sub-addresses read as zero
	assign rdata      = sel_ctrl ? ctrl_q : (sel_volt ? volt_q : 8'h00);

	always_comb begin
		state_d     = state_q;
		phase_d     = phase_q;
		bit_idx_d   = bit_idx_q;
		shift_d     = shift_q;
		byte_full_d = byte_full_q;
		rw_d        = rw_q;
		sub_d       = sub_q;
		tx_d        = tx_q;
		nack_d      = nack_q;
		busy_d      = busy_q;
		wr_en       = 1'h0;
		if (start_det) begin
			// a repeated START restarts the frame from the address byte
			state_d     = ST_RX;
			phase_d     = PH_ADDR;
			bit_idx_d   = 3'h0;
			byte_full_d = 1'h0;
			busy_d      = 1'h1;
		end else if (stop_det) begin
			state_d = ST_IDLE;
			busy_d  = 1'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_RX: begin
					if (bit_evt) begin
						shift_d   = {shift_q[6:0], rx_bit};
						bit_idx_d = bit_idx_q + 3'h1;
						if (bit_idx_q == `RC_LAST_BIT_IDX) begin
							byte_full_d = 1'h1;
						end
					end else if (scl_fall && byte_full_q) begin
						byte_full_d = 1'h0;
						case (phase_q)
							PH_ADDR: begin
								if (addr_match) begin
									rw_d    = shift_q[0];
									state_d = ST_ACK;
								end else begin
									state_d = ST_SKIP;
								end
							end
							PH_SUB: begin
								sub_d   = shift_q;
								state_d = ST_ACK;
							end
							PH_DATA: begin
								wr_en   = 1'h1;
								state_d = ST_ACK;
							end
							default: begin
								state_d = ST_SKIP;
							end
						endcase
					end
				end
				ST_ACK: begin
					// the ack bit's own capture is not data; leave on its falling edge
					if (scl_fall) begin
						bit_idx_d = 3'h0;
						if (phase_q == PH_ADDR && rw_q) begin
							tx_d    = rdata;
							phase_d = PH_DATA;
							state_d = ST_TX;
						end else begin
							// writes keep acknowledging as long as the master sends
							phase_d = (phase_q == PH_ADDR) ? PH_SUB : PH_DATA;
							state_d = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_idx_q == `RC_LAST_BIT_IDX) begin
							state_d = ST_TXACK;
						end else begin
							bit_idx_d = bit_idx_q + 3'h1;
							tx_d      = {tx_q[6:0], 1'h0};
						end
					end
				end
				ST_TXACK: begin
					if (bit_evt) begin
						nack_d = rx_bit;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_d = ST_SKIP;
						end else begin
							tx_d      = rdata;
							bit_idx_d = 3'h0;
							state_d   = ST_TX;
						end
					end
				end
				ST_SKIP: begin
					state_d = ST_SKIP;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// open drain: only ever pull low, during ack or a zero read bit
	always_comb begin
		case (state_d)
			ST_ACK:  oe_n_d = 1'h0;
			ST_TX:   oe_n_d = tx_d[7];
			default: oe_n_d = 1'h1;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_IDLE;
			phase_q <= PH_ADDR;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_idx_q   <= 3'h0;
			shift_q     <= 8'h00;
			byte_full_q <= 1'h0;
		end else begin
			bit_idx_q   <= bit_idx_d;
			shift_q     <= shift_d;
			byte_full_q <= byte_full_d;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rw_q   <= 1'h0;
			sub_q  <= 8'h00;
			tx_q   <= 8'h00;
			nack_q <= 1'h0;
		end else begin
			rw_q   <= rw_d;
			sub_q  <= sub_d;
			tx_q   <= tx_d;
			nack_q <= nack_d;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			oe_n_q <= 1'h1;
			busy_q <= 1'h0;
		end else begin
			oe_n_q <= oe_n_d;
			busy_q <= busy_d;
		end
	end

	// register writes; reserved bits are masked off on the way in
	logic [7:0]             ctrl_wr;
	logic [7:0]             volt_wr;

	assign ctrl_wr = shift_q & `RC_CONVERTER_CONTROL_MASK;
	assign volt_wr = shift_q & `RC_OUTPUT_VOLTAGE_MASK;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q <= `RC_CONVERTER_CONTROL_RESET;
		end else if (wr_en && sel_ctrl) begin
			ctrl_q <= ctrl_wr;
		end
	end

	// the code is applied as written; slewing it in single steps is the host's job
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			volt_q <= `RC_OUTPUT_VOLTAGE_RESET;
		end else if (wr_en && sel_volt) begin
			volt_q <= volt_wr;
		end
	end

	// outputs
	assign sda_o                    = 1'h0;
	assign sda_oe_n_o               = oe_n_q;
	assign bus_busy_o               = busy_q;
	assign switching_freq_select_o  = ctrl_q[`RC_FREQ_SEL_MSB:`RC_FREQ_SEL_LSB];
	assign forced_continuous_mode_o = ctrl_q[`RC_FORCED_CCM_BIT];
	assign converter_disable_o      = ctrl_q[`RC_CONV_DISABLE_BIT];
	assign output_voltage_code_o    = volt_q[`RC_VOLT_CODE_MSB:`RC_VOLT_CODE_LSB];

endmodule

// ===== design/regctl_map.svh
// register offsets, field positions and reset values of the regulator control slave
`ifndef REGCTL_MAP_SVH
`define REGCTL_MAP_SVH

// 7-bit slave address 1110010
`define RC_SLAVE_ADDR              7'h72

// sub-addresses of the two registers
`define RC_SUB_CONVERTER_CONTROL   8'h10
`define RC_SUB_OUTPUT_VOLTAGE      8'h11

// reset values
`define RC_CONVERTER_CONTROL_RESET 8'h00
`define RC_OUTPUT_VOLTAGE_RESET    8'h00

// writable bits; everything else is reserved and reads as zero
`define RC_CONVERTER_CONTROL_MASK  8'h73
`define RC_OUTPUT_VOLTAGE_MASK     8'h0F

// field positions of converter_control
`define RC_FREQ_SEL_MSB            6
`define RC_FREQ_SEL_LSB            4
`define RC_FORCED_CCM_BIT          1
`define RC_CONV_DISABLE_BIT        0

// field positions of output_voltage_setting
`define RC_VOLT_CODE_MSB           3
`define RC_VOLT_CODE_LSB           0

// bit index of the last bit of a byte
`define RC_LAST_BIT_IDX            3'h7

`endif

// ===== design/regctl_pkg.sv
// types shared by the regulator control slave
package regctl_pkg;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_RX    = 6'h02,
		ST_ACK   = 6'h04,
		ST_TX    = 6'h08,
		ST_TXACK = 6'h10,
		ST_SKIP  = 6'h20
	} link_state_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'h1,
		PH_SUB  = 3'h2,
		PH_DATA = 3'h4
	} byte_phase_t;

endpackage

// ===== design/sync2.sv
// two flip-flop synchroniser for levels entering the clk_i domain
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q   <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= async_i;
			stable_q <= meta_q;
		end
	end

	assign sync_o = stable_q;

endmodule

// ===== tb/regctl_assertions.sv
// port-level checks of the regulator control slave
`timescale 1ns/1ps
module regctl_checker (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n_o,
	input wire logic       bus_busy_o,
	input wire logic [2:0] switching_freq_select_o,
	input wire logic       forced_continuous_mode_o,
	input wire logic       converter_disable_o,
	input wire logic [3:0] output_voltage_code_o
);
	wire logic [8:0] regs_w = {switching_freq_select_o, forced_continuous_mode_o,
		converter_disable_o, output_voltage_code_o};
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// wire levels are sampled raw, so bounds allow for the two-flop sync delay
	a_data_zero: assert property (sda_o == 1'b0)
		else $error("open-drain data value not low");
	a_oe_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("data drive changed while clock high");
	a_start_busy: assert property (scl_i && $past(scl_i) && $fell(sda_i)
		|-> ##[1:6] bus_busy_o)
		else $error("start not flagged busy");
	a_stop_free: assert property (scl_i && $past(scl_i) && $rose(sda_i)
		|-> ##[1:6] !bus_busy_o)
		else $error("stop not flagged free");
	a_busy_rise: assert property ($rose(bus_busy_o) |-> scl_i && !sda_i)
		else $error("busy rose without start");
	a_busy_fall: assert property ($fell(bus_busy_o) |-> scl_i && sda_i)
		else $error("busy fell without stop");
	a_oe_framed: assert property (!sda_oe_n_o |-> bus_busy_o)
		else $error("data driven outside a frame");
	a_ack_stands: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
		else $error("low drive too short");
	a_regs_framed: assert property ($changed(regs_w) |-> bus_busy_o && !scl_i)
		else $error("register changed outside a write");
endmodule
bind i2c_regulator_control_slave regctl_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.bus_busy_o(bus_busy_o), .switching_freq_select_o(switching_freq_select_o),
	.forced_continuous_mode_o(forced_continuous_mode_o),
	.converter_disable_o(converter_disable_o), .output_voltage_code_o(output_voltage_code_o));

// ===== tb/i2c_host_model.sv
// bus master model for the two-wire link
`timescale 1ns/1ps
module i2c_host_model (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	logic lclk;
	initial begin
		lclk = 1'b0;
		forever #40 lclk = ~lclk;
	end
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge lclk);
	endtask
	// only this side makes start and stop; scl stands high between frames
	task automatic start();
		tk(1);
		sda_low_o <= 1'b1;
		tk(8);
		scl_o <= 1'b0;
	endtask
	// repeated start from the low clock phase that ends an acknowledge bit
	task automatic restart();
		tk(4);
		sda_low_o <= 1'b0;
		tk(12);
		scl_o <= 1'b1;
		tk(8);
		start();
	endtask
	// idle gap after stop gives the bus its free time
	task automatic stop();
		tk(4);
		sda_low_o <= 1'b1;
		tk(8);
		scl_o <= 1'b1;
		tk(8);
		sda_low_o <= 1'b0;
		tk(16);
	endtask
	// 32 link cycles a bit, just under 400 kbps
	task automatic bit_io(input logic b, output logic r);
		tk(4);
		sda_low_o <= !b;
		tk(12);
		scl_o <= 1'b1;
		tk(8);
		r = sda_i;
		tk(8);
		scl_o <= 1'b0;
	endtask
	// eight bits msb first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, ak);
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the regulator control slave
`timescale 1ns/1ps
module testbench;
	logic       clk_i;
	logic       reset_n_i;
	logic       scl;
	logic       host_low;
	logic       sda_o;
	logic       sda_oe_n_o;
	logic       bus_busy_o;
	logic [2:0] freq_sel;
	logic       ccm_on;
	logic       cdis;
	logic [3:0] vcode;
	int         n_mismatch;
	int         checks_done;
	// open-drain line with pull-up
	wire        sda = !(host_low || !sda_oe_n_o);
	wire [7:0]  ctrl_w = {1'b0, freq_sel, 2'b00, ccm_on, cdis};

	i2c_regulator_control_slave dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .bus_busy_o(bus_busy_o),
		.switching_freq_select_o(freq_sel), .forced_continuous_mode_o(ccm_on),
		.converter_disable_o(cdis), .output_voltage_code_o(vcode));
	i2c_host_model host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] d, input logic [7:0] ak);
		logic [7:0] q;
		logic       a;
		host.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, ak);
	endtask
	// read with no sub-address, master ends with a nack
	task automatic rd(input logic [7:0] exp);
		logic [7:0] q;
		logic       a;
		host.start();
		put(8'hE5, 8'h00);
		host.xfer(8'hFF, 1'b1, q, a);
		host.stop();
		chk(q, exp);
	endtask
	task automatic t_reset();
		chk(ctrl_w, 8'h00);
		chk({4'h0, vcode}, 8'h00);
		chk({7'h00, sda_o}, 8'h00);
		rd(8'h00);
		$display("t_reset done");
	endtask
	task automatic t_ctrl();
		logic [7:0] d;
		host.start();
		chk({7'h00, bus_busy_o}, 8'h01);
		put(8'hE4, 8'h00);
		put(8'h10, 8'h00);
		for (int c = 0; c < 8; c++) begin
			d = {1'b1, c[2:0], 2'b11, c[1:0]};
			put(d, 8'h00);
			chk(ctrl_w, d & 8'h73);
		end
		host.stop();
		chk({7'h00, bus_busy_o}, 8'h00);
		rd(d & 8'h73);
		$display("t_ctrl done");
	endtask
	task automatic t_volt();
		host.start();
		put(8'hE4, 8'h00);
		put(8'h11, 8'h00);
		// one code step per byte, each more than 50 us after the last
		for (int v = 1; v < 16; v++) begin
			host.tk(626);
			put({4'hF, v[3:0]}, 8'h00);
			chk({4'h0, vcode}, {4'h0, v[3:0]});
		end
		host.stop();
		rd(8'h0F);
		host.start();
		put(8'hE4, 8'h00);
		put(8'h10, 8'h00);
		host.stop();
		rd(8'h73);
		$display("t_volt done");
	endtask
	task automatic t_foreign();
		host.start();
		put(8'hE6, 8'h01);
		put(8'h10, 8'h01);
		put(8'h00, 8'h01);
		host.stop();
		chk(ctrl_w, 8'h73);
		$display("t_foreign done");
	endtask
	// unmapped write is dropped; repeated start, then a two-byte read
	task automatic t_multi();
		logic [7:0] q;
		logic       a;
		host.start();
		put(8'hE4, 8'h00);
		put(8'h20, 8'h00);
		put(8'h55, 8'h00);
		host.stop();
		chk(ctrl_w, 8'h73);
		chk({4'h0, vcode}, 8'h0F);
		rd(8'h00);
		host.start();
		put(8'hE4, 8'h00);
		put(8'h11, 8'h00);
		host.restart();
		put(8'hE5, 8'h00);
		host.xfer(8'hFF, 1'b0, q, a);
		chk(q, 8'h0F);
		host.xfer(8'hFF, 1'b1, q, a);
		host.stop();
		chk(q, 8'h0F);
		$display("t_multi done");
	endtask
	// reset in mid-run returns every register and the bus state to idle
	task automatic t_rst_mid();
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk(ctrl_w, 8'h00);
		chk({4'h0, vcode}, 8'h00);
		reset_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({7'h00, bus_busy_o}, 8'h00);
		chk({7'h00, sda_oe_n_o}, 8'h01);
		$display("t_rst_mid done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		reset_n_i = 1'b0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		// idle bus for a few edges so the synchronisers settle first
		repeat (8) @(posedge clk_i);
		t_reset();
		t_ctrl();
		t_volt();
		t_foreign();
		t_multi();
		t_rst_mid();
		report_and_stop();
	end
	// the full sequence needs about 2 ms, mostly the paced voltage steps
	initial begin
		#2400000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
